// File: spi_flag_pkg.sv
// constants shared by the spi status flag sequencer and its test bench
// assumes a 32-bit classic wishbone bus with byte selects
package spi_flag_pkg;

  // register word offsets (byte addresses)
  localparam logic [7:0] OFF_STATUS   = 8'h00;
  localparam logic [7:0] OFF_DATA     = 8'h04;
  localparam logic [7:0] OFF_CTRL_ONE = 8'h08;
  localparam logic [7:0] OFF_CTRL_TWO = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

  // serial_status field positions
  localparam int RCV_BIT   = 7;
  localparam int EMPTY_BIT = 5;
  localparam int FAULT_BIT = 4;

  // control_one field positions
  localparam int MASTER_BIT = 4;
  localparam int IRQ_EN_BIT = 7;

  // control_two field positions
  localparam int FAULT_EN_BIT = 4;
  localparam int WIDTH_BIT    = 6;

  // interrupt status / mask layout
  localparam int IRQ_RCV   = 0;
  localparam int IRQ_EMPTY = 1;
  localparam int IRQ_FAULT = 2;
  localparam int NUM_FLAGS = 3;

  // flag order inside the flag cell array
  localparam int F_RCV   = 0;
  localparam int F_EMPTY = 1;
  localparam int F_FAULT = 2;

  // reset values
  localparam logic       RCV_RST      = 1'b0;
  localparam logic       EMPTY_RST    = 1'b1;
  localparam logic       FAULT_RST    = 1'b0;
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam logic [15:0] DATA_RST    = 16'h0000;

endpackage

// File: spi_flag_cell.sv
// one status flag with its armed state
// assumes set, arm and clear strobes are single-cycle and synchronous
`timescale 1ns/100ps
`default_nettype none
module spi_flag_cell #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  input  wire logic arm_i,
  input  wire logic clr_i,
  output logic      flag_o,
  output logic      next_o,
  output logic      hit_o
);

  logic flag_q;
  logic armed_q;
  logic armed_d;
  logic clr_hit;

  // a status read arms the cell only if it saw the flag set
  assign clr_hit = clr_i & armed_q;
  // set wins over a clear in the same cycle
  assign next_o  = set_i | (flag_q & ~clr_hit);
  assign armed_d = arm_i ? flag_q : (clr_hit ? 1'b0 : armed_q);
  assign flag_o  = flag_q;
  // lets the owner see an armed clear without a loop through next_o
  assign hit_o   = clr_hit;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q  <= RST_VAL;
      armed_q <= 1'b0;
    end else begin
      flag_q  <= next_o;
      armed_q <= armed_d;
    end
  end

endmodule
`default_nettype wire

// File: spi_status_flag_sequencer.sv
// status flag sequencer of a serial peripheral interface, wishbone slave
// assumes an external shift engine: it pulses shift done with received
// data, takes queued transmit data with a take pulse, and supplies ss_n
//
// How it works
// - receive_complete_flag at status bit 7 sets once received data lands
// - transmit_empty_flag at status bit 5 reads 1 when transmit register empty
// - mode_fault_flag bit 4 sets when ss falls as master with detection on
// - armed mode fault clears on the next write to control_one
// - status reads anytime; writes to it change nothing
// - 8-bit width: status read seeing flag, then low byte read clears receive
// - 16-bit width: only a low byte read, alone or in a word, clears
// - high byte reads never touch the receive flag
// - 8-bit width: status read seeing empty, then low byte write clears
// - 16-bit width: only a low byte write, alone or in a word, clears
// - data writes while transmit_empty_flag is 0 are dropped
// - high byte writes never touch the transmit empty flag
// - with receive flag clear, a finished frame loads data and sets flag
// - mode fault raises an interrupt event only with irq_enable set
`timescale 1ns/100ps
`default_nettype none
module spi_status_flag_sequencer
  import spi_flag_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  input  wire logic        SS_N_I,
  input  wire logic        SHIFT_DONE_I,
  input  wire logic [15:0] RX_WORD_I,
  input  wire logic        TX_TAKE_I,
  output logic      [15:0] TX_WORD_O,
  output logic             TX_VALID_O,
  output logic             MASTER_O,
  output logic             WIDTH16_O,
  output logic             FAULT_EN_O,
  output logic             IRQ_O
);

  // bus decode
  logic        req;
  logic        rd;
  logic        wr;
  logic        hit_status;
  logic        hit_data;
  logic        hit_ctrl_one;
  logic        hit_ctrl_two;
  logic        hit_irq_stat;
  logic        hit_irq_mask;
  logic        lo_lane;
  logic        hi_lane;

  // registers
  logic        ack_q;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic [7:0]  ctrl_one_q;
  logic [7:0]  ctrl_one_d;
  logic [7:0]  ctrl_two_q;
  logic [7:0]  ctrl_two_d;
  logic [15:0] rx_data_q;
  logic [15:0] rx_data_d;
  logic [15:0] pend_data_q;
  logic [15:0] pend_data_d;
  logic        pend_q;
  logic        pend_d;
  logic [15:0] tx_data_q;
  logic [15:0] tx_data_d;
  logic        tx_valid_q;
  logic        ss_n_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_stat_d;
  logic [2:0]  irq_mask_q;
  logic [2:0]  irq_mask_d;
  logic        irq_q;

  // flag cell strobes
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  logic [NUM_FLAGS-1:0] flag_q;
  logic [NUM_FLAGS-1:0] flag_d;
  logic [NUM_FLAGS-1:0] flag_hit;

  // reset pattern in flag cell order: fault, empty, receive
  localparam logic [NUM_FLAGS-1:0] FLAG_RST = {FAULT_RST, EMPTY_RST, RCV_RST};

  // events
  logic        status_rd;
  logic        lo_rd;
  logic        lo_wr;
  logic        hi_wr;
  logic        tx_open;
  logic        rx_clear;
  logic        rx_load;
  logic        pend_load;
  logic        fault_evt;
  logic        ctrl_one_wr;
  logic [7:0]  status_byte;
  logic [2:0]  irq_evt;

  // request is taken in the cycle before ack, so back-to-back
  // cycles never act twice on the same strobe
  assign req = CYC_I & STB_I & ~ack_q;
  assign rd  = req & ~WE_I;
  assign wr  = req & WE_I;

  assign hit_status   = (ADR_I == OFF_STATUS);
  assign hit_data     = (ADR_I == OFF_DATA);
  assign hit_ctrl_one = (ADR_I == OFF_CTRL_ONE);
  assign hit_ctrl_two = (ADR_I == OFF_CTRL_TWO);
  assign hit_irq_stat = (ADR_I == OFF_IRQ_STAT);
  assign hit_irq_mask = (ADR_I == OFF_IRQ_MASK);

  // low data byte on lane 0, high data byte on lane 1
  assign lo_lane = SEL_I[0];
  assign hi_lane = SEL_I[1];

  // status reads never change flags themselves; only arm cells
  assign status_rd = rd & hit_status;

  // high byte reads are not part of the clear condition
  assign lo_rd = rd & hit_data & lo_lane;

  // data writes count only while the transmit register is empty
  assign tx_open = flag_q[F_EMPTY];
  assign lo_wr   = wr & hit_data & lo_lane & tx_open;
  assign hi_wr   = wr & hit_data & hi_lane & tx_open;

  assign ctrl_one_wr = wr & hit_ctrl_one & lo_lane;

  // receive side
  // a low byte read that hits an armed flag frees the data register
  assign rx_clear  = lo_rd;
  assign rx_load   = SHIFT_DONE_I & ~flag_q[F_RCV];
  // the waiting word moves up when an armed clear frees the data register,
  // or when a clear and a frame met in one cycle and left it waiting
  assign pend_load = pend_q & ((flag_q[F_RCV] & flag_hit[F_RCV])
                     | (~flag_q[F_RCV] & ~SHIFT_DONE_I));

  // mode fault: falling slave select seen as master with detection on
  assign fault_evt = ctrl_one_q[MASTER_BIT] & ctrl_two_q[FAULT_EN_BIT]
                     & ss_n_q & ~SS_N_I;

  assign flag_set[F_RCV]   = rx_load | pend_load;
  assign flag_set[F_EMPTY] = TX_TAKE_I & ~flag_q[F_EMPTY];
  assign flag_set[F_FAULT] = fault_evt;

  assign flag_clr[F_RCV]   = rx_clear;
  assign flag_clr[F_EMPTY] = lo_wr;
  assign flag_clr[F_FAULT] = ctrl_one_wr;

  // the receive cell's hit tells the pending slot when the data register frees
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
      spi_flag_cell #(
        .RST_VAL (FLAG_RST[gi])
      ) u_cell (
        .clk_i  (CLK_I),
        .rst_i  (SYS_RST_I),
        .set_i  (flag_set[gi]),
        .arm_i  (status_rd),
        .clr_i  (flag_clr[gi]),
        .flag_o (flag_q[gi]),
        .next_o (flag_d[gi]),
        .hit_o  (flag_hit[gi])
      );
    end
  endgenerate

  // status byte view
  always_comb begin
    status_byte            = 8'h00;
    status_byte[RCV_BIT]   = flag_q[F_RCV];
    status_byte[EMPTY_BIT] = flag_q[F_EMPTY];
    status_byte[FAULT_BIT] = flag_q[F_FAULT];
  end

  // received data holding and the one-deep pending slot
  // a second frame waits in the pending slot; a new transmit start
  // while it waits makes it stale, as a third frame would overrun it
  always_comb begin
    rx_data_d   = rx_data_q;
    pend_data_d = pend_data_q;
    pend_d      = pend_q;
    // a fresh frame into an empty register makes any waiting word stale
    if (rx_load) begin
      rx_data_d = RX_WORD_I;
      pend_d    = 1'b0;
    end else if (pend_load) begin
      rx_data_d = pend_data_q;
      pend_d    = 1'b0;
    end
    // a frame that meets a set flag waits; a newer one overwrites it
    if (SHIFT_DONE_I && flag_q[F_RCV]) begin
      pend_data_d = RX_WORD_I;
      pend_d      = 1'b1;
    end else if (TX_TAKE_I && pend_q && !pend_load) begin
      pend_d = 1'b0;
    end
  end

  // transmit data: high byte may be rewritten freely before the low byte
  always_comb begin
    tx_data_d = tx_data_q;
    if (hi_wr) begin
      tx_data_d[15:8] = DAT_I[15:8];
    end
    if (lo_wr) begin
      tx_data_d[7:0] = DAT_I[7:0];
    end
  end

  // control registers; a mode fault drops the master bit at once
  always_comb begin
    ctrl_one_d = ctrl_one_q;
    ctrl_two_d = ctrl_two_q;
    if (ctrl_one_wr) begin
      ctrl_one_d = DAT_I[7:0];
    end
    if (wr && hit_ctrl_two && lo_lane) begin
      ctrl_two_d = DAT_I[7:0];
    end
    if (fault_evt) begin
      ctrl_one_d[MASTER_BIT] = 1'b0;
    end
  end

  // interrupt events are gated by irq_enable at the moment they occur
  assign irq_evt[IRQ_RCV]   = flag_set[F_RCV] & ~flag_q[F_RCV]
                              & ctrl_one_q[IRQ_EN_BIT];
  assign irq_evt[IRQ_EMPTY] = flag_set[F_EMPTY] & ctrl_one_q[IRQ_EN_BIT];
  assign irq_evt[IRQ_FAULT] = fault_evt & ctrl_one_q[IRQ_EN_BIT];

  // write one to clear; a new event in the same cycle wins
  always_comb begin
    irq_stat_d = irq_stat_q;
    irq_mask_d = irq_mask_q;
    if (wr && hit_irq_stat && lo_lane) begin
      irq_stat_d = irq_stat_q & ~DAT_I[2:0];
    end
    irq_stat_d = irq_stat_d | irq_evt;
    if (wr && hit_irq_mask && lo_lane) begin
      irq_mask_d = DAT_I[2:0];
    end
  end

  // read mux; unmapped addresses read as zero but still acknowledge
  always_comb begin
    dat_d = 32'h0000_0000;
    if (rd) begin
      if (hit_status) begin
        dat_d[7:0] = status_byte;
      end else if (hit_data) begin
        dat_d[15:0] = rx_data_q;
      end else if (hit_ctrl_one) begin
        dat_d[7:0] = ctrl_one_q;
      end else if (hit_ctrl_two) begin
        dat_d[7:0] = ctrl_two_q;
      end else if (hit_irq_stat) begin
        dat_d[2:0] = irq_stat_q;
      end else if (hit_irq_mask) begin
        dat_d[2:0] = irq_mask_q;
      end else begin
        dat_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      dat_q <= dat_d;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      rx_data_q   <= DATA_RST;
      pend_data_q <= DATA_RST;
      pend_q      <= 1'b0;
      tx_data_q   <= DATA_RST;
    end else begin
      rx_data_q   <= rx_data_d;
      pend_data_q <= pend_data_d;
      pend_q      <= pend_d;
      tx_data_q   <= tx_data_d;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ctrl_one_q <= CTRL_ONE_RST;
      ctrl_two_q <= CTRL_TWO_RST;
      irq_stat_q <= 3'h0;
      irq_mask_q <= IRQ_MASK_RST;
    end else begin
      ctrl_one_q <= ctrl_one_d;
      ctrl_two_q <= ctrl_two_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // ss_n is taken as synchronous; previous sample finds the falling edge
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ss_n_q     <= 1'b1;
      tx_valid_q <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      ss_n_q     <= SS_N_I;
      // valid follows the next empty state so it never lags the flag
      tx_valid_q <= ~flag_d[F_EMPTY];
      irq_q      <= |(irq_stat_d & irq_mask_d);
    end
  end

  // every output straight from a flip-flop
  assign ACK_O      = ack_q;
  assign DAT_O      = dat_q;
  assign TX_WORD_O  = tx_data_q;
  assign TX_VALID_O = tx_valid_q;
  assign MASTER_O   = ctrl_one_q[MASTER_BIT];
  assign WIDTH16_O  = ctrl_two_q[WIDTH_BIT];
  assign FAULT_EN_O = ctrl_two_q[FAULT_EN_BIT];
  assign IRQ_O      = irq_q;

endmodule
`default_nettype wire

// File: spi_status_flag_sequencer_checker.sv
// port checker for the status flag sequencer
// assumes a bind onto the sequencer top, one clock domain
`timescale 1ns/100ps
`default_nettype none
module spi_status_flag_sequencer_checker (
  input wire logic        CLK_I,
  input wire logic        SYS_RST_I,
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        WE_I,
  input wire logic [7:0]  ADR_I,
  input wire logic [3:0]  SEL_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  input wire logic        SS_N_I,
  input wire logic        SHIFT_DONE_I,
  input wire logic        TX_TAKE_I,
  input wire logic [15:0] TX_WORD_O,
  input wire logic        TX_VALID_O,
  input wire logic        MASTER_O,
  input wire logic        FAULT_EN_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence s_take; CYC_I && STB_I && !ACK_O; endsequence
  sequence s_stat_rd; s_take ##0 (!WE_I && ADR_I == 8'h00); endsequence
  sequence s_data_wr; s_take ##0 (WE_I && ADR_I == 8'h04); endsequence
  a_ack_single: assert property (s_take |=> ACK_O ##1 !ACK_O)
    else $error("ack is not one pulse a cycle after the request");
  a_empty_seen: assert property (s_stat_rd |=> DAT_O[5] == !$past(TX_VALID_O))
    else $error("empty bit disagrees with transmit valid");
  // window of two: a second request cannot fit, so no clear can sneak in
  a_rcv_report: assert property (SHIFT_DONE_I ##[1:2] s_stat_rd |=> DAT_O[7])
    else $error("receive bit missing after frame");
  a_take_empty: assert property (TX_TAKE_I && TX_VALID_O |=> !TX_VALID_O)
    else $error("transmit valid held after take");
  a_busy_drop: assert property (s_data_wr ##0 (TX_VALID_O && !TX_TAKE_I)
    |=> TX_VALID_O && $stable(TX_WORD_O))
    else $error("data write accepted while not empty");
  a_high_only: assert property (s_data_wr ##0 (!SEL_I[0] && !TX_VALID_O) |=> !TX_VALID_O)
    else $error("high byte write queued data");
  a_status_ro: assert property (s_take ##0 (WE_I && ADR_I == 8'h00 && !TX_TAKE_I)
    |=> $stable(TX_VALID_O))
    else $error("status write changed a flag");
  a_fault_drop: assert property ($fell(SS_N_I) && MASTER_O && FAULT_EN_O |=> !MASTER_O)
    else $error("mode fault did not leave master mode");
endmodule
bind spi_status_flag_sequencer spi_status_flag_sequencer_checker chk_u (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
  .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .SS_N_I(SS_N_I),
  .SHIFT_DONE_I(SHIFT_DONE_I), .TX_TAKE_I(TX_TAKE_I), .TX_WORD_O(TX_WORD_O),
  .TX_VALID_O(TX_VALID_O), .MASTER_O(MASTER_O), .FAULT_EN_O(FAULT_EN_O));
`default_nettype wire

// File: spi_far_end.sv
// far-side shift engine: takes queued words, returns frames after a lag
// assumes the bench sets lag and fault; one clock, sync reset
`timescale 1ns/100ps
`default_nettype none
module spi_far_end (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  lag_i,
  input  wire logic        fault_i,
  input  wire logic        tx_valid_i,
  input  wire logic [15:0] tx_word_i,
  output logic             take_o,
  output logic             done_o,
  output logic      [15:0] rx_word_o,
  output logic             ss_n_o
);
  logic [3:0]  cnt_q;
  logic        busy_q;
  logic [15:0] sent_q;
  always_ff @(posedge clk_i) begin
    take_o <= 1'b0;
    done_o <= 1'b0;
    // outside a frame the word toggles so a stale capture shows up
    rx_word_o <= ~rx_word_o;
    ss_n_o <= ~fault_i;
    if (rst_i) begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      rx_word_o <= 16'h0;
      ss_n_o <= 1'b1;
    end else if (!busy_q && tx_valid_i && !take_o) begin
      cnt_q <= (cnt_q == lag_i) ? 4'h0 : cnt_q + 4'h1;
      take_o <= (cnt_q == lag_i);
      busy_q <= (cnt_q == lag_i);
      sent_q <= tx_word_i;
    end else if (busy_q) begin
      cnt_q <= (cnt_q == lag_i) ? 4'h0 : cnt_q + 4'h1;
      done_o <= (cnt_q == lag_i);
      busy_q <= (cnt_q != lag_i);
      if (cnt_q == lag_i) rx_word_o <= sent_q ^ 16'h5aa5;
    end
  end
endmodule
`default_nettype wire

// File: spi_status_flag_sequencer_tb_top.sv
// self-checking bench for the status flag sequencer
// assumes the far-end model and the bound checker are compiled alongside
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module spi_status_flag_sequencer_tb_top;
  import spi_flag_pkg::*;
  logic        clk, rst, cyc, stb, we, ss_n, done, take, tx_valid, master, irq, ack, fault;
  logic        width16, fault_en;
  logic [3:0]  lag, sel;
  logic [7:0]  adr;
  logic [15:0] rx_word, tx_word;
  logic [31:0] dat_w, dat_r;
  int          err_total, num_checks, cycles;
  spi_status_flag_sequencer dut_u (
    .CLK_I(clk), .SYS_RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .SS_N_I(ss_n),
    .SHIFT_DONE_I(done), .RX_WORD_I(rx_word), .TX_TAKE_I(take), .TX_WORD_O(tx_word),
    .TX_VALID_O(tx_valid), .MASTER_O(master), .WIDTH16_O(width16),
    .FAULT_EN_O(fault_en), .IRQ_O(irq));
  spi_far_end far_u (.clk_i(clk), .rst_i(rst), .lag_i(lag), .fault_i(fault),
    .tx_valid_i(tx_valid), .tx_word_i(tx_word), .take_o(take), .done_o(done),
    .rx_word_o(rx_word), .ss_n_o(ss_n));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [15:0] rx_of(input logic [15:0] t);
    return t ^ 16'h5aa5;
  endfunction
  task automatic complete_run();
    if (err_total == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat_w} <= {2'h3, w, a, s, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    r = dat_r;
    {cyc, stb, we} <= 3'h0;
  endtask
  task automatic wait_rx(output logic [31:0] r);
    int n;
    n = 0;
    do begin
      wb(1'b0, OFF_STATUS, 4'hf, 32'h0, r);
      n++;
    end while (r[7] !== 1'b1 && n < 40);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    logic [31:0] r;
    logic [15:0] w, e;
    logic [3:0]  s;
    int          m;
    {rst, cyc, stb, we, adr, sel, dat_w, lag, fault} = '0;
    rst = 1'b1;
    {err_total, num_checks, cycles} = '0;
    r = $urandom(19362);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wb(1'b1, OFF_DATA, 4'h1, 32'h5a, r);
    @(negedge clk);
    `CHK(tx_valid, 1'b0)
    wb(1'b1, OFF_STATUS, 4'hf, 32'hff, r);
    wb(1'b0, OFF_STATUS, 4'hf, 32'h0, r);
    `CHK(r[7:0], 8'h20)
    wb(1'b0, 8'h3c, 4'hf, 32'h0, r);
    `CHK(r, 32'h0)
    for (m = 0; m < 3; m++) begin
      lag <= 4'($urandom % 8);
      w = 16'($urandom);
      e = rx_of(w);
      s = (m == 2) ? 4'h3 : 4'h1;
      wb(1'b1, OFF_CTRL_TWO, 4'h1, 32'(m != 0) << WIDTH_BIT, r);
      `CHK(width16, 1'(m != 0))
      wb(1'b0, OFF_STATUS, 4'hf, 32'h0, r);
      if (m == 1) begin
        repeat (2) wb(1'b1, OFF_DATA, 4'h2, {16'h0, w}, r);
        @(negedge clk);
        `CHK(tx_valid, 1'b0)
      end
      wb(1'b1, OFF_DATA, s, {16'h0, w}, r);
      @(negedge clk);
      `CHK(tx_valid, 1'b1)
      `CHK(tx_word[7:0], w[7:0])
      wait_rx(r);
      `CHK(r[7:0], 8'ha0)
      if (m != 0) begin
        repeat (2) wb(1'b0, OFF_DATA, 4'h2, 32'h0, r);
        `CHK(r[15:8], e[15:8])
        wb(1'b0, OFF_STATUS, 4'hf, 32'h0, r);
        `CHK(r[7], 1'b1)
      end
      wb(1'b0, OFF_DATA, s, 32'h0, r);
      `CHK(r[7:0], e[7:0])
      wb(1'b0, OFF_STATUS, 4'hf, 32'h0, r);
      `CHK(r[7:0], 8'h20)
    end
    lag <= 4'hf;
    wb(1'b0, OFF_STATUS, 4'hf, 32'h0, r);
    wb(1'b1, OFF_DATA, 4'h3, 32'h1234, r);
    wb(1'b1, OFF_DATA, 4'h3, 32'hbeef, r);
    @(negedge clk);
    `CHK(tx_word, 16'h1234)
    wait_rx(r);
    wb(1'b0, OFF_DATA, 4'h3, 32'h0, r);
    e = rx_of(16'h1234);
    `CHK(r[15:0], e)
    // second frame while the flag is still set waits, then moves up on clear
    lag <= 4'h3;
    wb(1'b0, OFF_STATUS, 4'hf, 32'h0, r);
    wb(1'b1, OFF_DATA, 4'h3, 32'h0f0f, r);
    wait_rx(r);
    wb(1'b1, OFF_DATA, 4'h3, 32'hc3c3, r);
    repeat (20) @(posedge clk);
    wb(1'b0, OFF_DATA, 4'h3, 32'h0, r);
    e = rx_of(16'h0f0f);
    `CHK(r[15:0], e)
    wb(1'b0, OFF_STATUS, 4'hf, 32'h0, r);
    `CHK(r[7], 1'b1)
    wb(1'b0, OFF_DATA, 4'h3, 32'h0, r);
    e = rx_of(16'hc3c3);
    `CHK(r[15:0], e)
    wb(1'b1, OFF_IRQ_MASK, 4'h1, 32'h7, r);
    wb(1'b1, OFF_CTRL_TWO, 4'h1, 32'h1 << FAULT_EN_BIT, r);
    `CHK(fault_en, 1'b1)
    wb(1'b1, OFF_CTRL_ONE, 4'h1, (32'h1 << IRQ_EN_BIT) | (32'h1 << MASTER_BIT), r);
    fault <= 1'b1;
    repeat (3) @(posedge clk);
    fault <= 1'b0;
    repeat (3) @(negedge clk);
    `CHK(master, 1'b0)
    `CHK(irq, 1'b1)
    wb(1'b1, OFF_CTRL_ONE, 4'h1, 32'h1 << IRQ_EN_BIT, r);
    wb(1'b0, OFF_STATUS, 4'hf, 32'h0, r);
    `CHK(r[4], 1'b1)
    wb(1'b1, OFF_CTRL_ONE, 4'h1, 32'h1 << IRQ_EN_BIT, r);
    wb(1'b0, OFF_STATUS, 4'hf, 32'h0, r);
    `CHK(r[4], 1'b0)
    wb(1'b1, OFF_IRQ_MASK, 4'h1, 32'h0, r);
    @(negedge clk);
    `CHK(irq, 1'b0)
    wb(1'b1, OFF_IRQ_STAT, 4'h1, 32'h7, r);
    wb(1'b1, OFF_IRQ_MASK, 4'h1, 32'h7, r);
    @(negedge clk);
    `CHK(irq, 1'b0)
    // empty and receive events raise the line while irq_enable stays set
    wb(1'b0, OFF_STATUS, 4'hf, 32'h0, r);
    wb(1'b1, OFF_DATA, 4'h1, 32'h3c, r);
    repeat (30) @(posedge clk);
    `CHK(irq, 1'b1)
    wb(1'b0, OFF_IRQ_STAT, 4'h1, 32'h0, r);
    `CHK(r[2:0], 3'h3)
    complete_run();
  end
endmodule
`default_nettype wire
